// >>> logic/asm_consts.svh
// Offsets, field positions and reset values of the amplifier status monitor bank
`ifndef ASM_CONSTS_SVH
`define ASM_CONSTS_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define ASM_OFF_CH0_FREQ_POWER 8'h60
`define ASM_OFF_CH0_PROTECT 8'h61
`define ASM_OFF_CH0_MOD_INDEX 8'h62
`define ASM_OFF_CH1_FREQ_POWER 8'h64
`define ASM_OFF_CH1_PROTECT 8'h65
`define ASM_OFF_CH1_MOD_INDEX 8'h66
`define ASM_OFF_FAULT_STICKY 8'h6D
`define ASM_OFF_OUTCFG_VIEW 8'h75
`define ASM_OFF_FAULT_LIVE 8'h7C

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define ASM_FP_FREQ_MSB 6
`define ASM_FP_FREQ_LSB 4
`define ASM_FP_POWER_MSB 1
`define ASM_FP_POWER_LSB 0
`define ASM_PS_MUTE_BIT 5
`define ASM_PS_CORE_GOOD_BIT 4
`define ASM_PS_POWER_GOOD_BIT 3
`define ASM_PS_FLYCAP_TWO_BIT 2
`define ASM_PS_FLYCAP_ONE_BIT 1
`define ASM_PS_OVERCURRENT_BIT 0
`define ASM_FAULT_FLYCAP_OV_BIT 0
`define ASM_FAULT_OVERCURRENT_BIT 1
`define ASM_FAULT_PLL_BIT 2
`define ASM_FAULT_UNDERVOLT_BIT 3
`define ASM_FAULT_OT_WARN_BIT 4
`define ASM_FAULT_OT_ERR_BIT 5
`define ASM_FAULT_LOW_IMP_BIT 6
`define ASM_FAULT_DC_BIT 7
`define ASM_OUTCFG_MSB 2

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define ASM_RST_BYTE 8'h00
`define ASM_RST_OUTCFG 3'h0

`endif

// >>> logic/asm_pkg.sv
// Types shared by the amplifier status monitor bank
package asm_pkg;

  typedef logic [7:0] asm_byte_t;
  typedef logic [2:0] asm_outcfg_t;

  typedef enum logic [3:0] {
    ASM_SEL_NONE = 4'h0,
    ASM_SEL_CH0_FREQ_POWER = 4'h1,
    ASM_SEL_CH0_PROTECT = 4'h2,
    ASM_SEL_CH0_MOD_INDEX = 4'h3,
    ASM_SEL_CH1_FREQ_POWER = 4'h4,
    ASM_SEL_CH1_PROTECT = 4'h5,
    ASM_SEL_CH1_MOD_INDEX = 4'h6,
    ASM_SEL_FAULT_STICKY = 4'h7,
    ASM_SEL_OUTCFG_VIEW = 4'h8,
    ASM_SEL_FAULT_LIVE = 4'h9
  } asm_reg_sel_t;

endpackage

// >>> logic/asm_chan_mon.sv
// Per-channel status capture: frequency/power, protection and modulation index bytes
`timescale 1ns/1ps
`include "asm_consts.svh"

module asm_chan_mon (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic ce,
  input wire logic overcurrent_clear,
  input wire logic [2:0] chan_freq_setting,
  input wire logic [1:0] chan_power_setting,
  input wire logic chan_muted,
  input wire logic core_supply_good,
  input wire logic power_supply_good,
  input wire logic flycap_two_good,
  input wire logic flycap_one_good,
  input wire logic overcurrent_guard,
  input wire logic [7:0] chan_mod_index,
  output asm_pkg::asm_byte_t freq_power_reg,
  output asm_pkg::asm_byte_t protect_reg,
  output asm_pkg::asm_byte_t mod_index_reg
);
  import asm_pkg::*;

  asm_byte_t freq_power_next;
  asm_byte_t protect_next;
  logic overcurrent_seen_reg;
  logic overcurrent_seen_next;

  // ----------------------------------------------------------------
  // Next values
  // ----------------------------------------------------------------
  assign freq_power_next = {1'b0, chan_freq_setting, 2'b00, chan_power_setting};
  // Event latched until cleared; a new event in the clear cycle survives
  assign overcurrent_seen_next = overcurrent_guard | (overcurrent_seen_reg & ~overcurrent_clear);
  assign protect_next = {2'b00, chan_muted, core_supply_good, power_supply_good,
                         flycap_two_good, flycap_one_good, overcurrent_seen_next};

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      freq_power_reg <= `ASM_RST_BYTE;
      protect_reg <= `ASM_RST_BYTE;
      mod_index_reg <= `ASM_RST_BYTE;
      overcurrent_seen_reg <= 1'b0;
    end else if (ce) begin
      freq_power_reg <= freq_power_next;
      protect_reg <= protect_next;
      mod_index_reg <= chan_mod_index;
      overcurrent_seen_reg <= overcurrent_seen_next;
    end
  end

endmodule // asm_chan_mon

// >>> logic/asm_status_monitor_regs.sv
// Read-only status monitor register bank of a two-channel class-D amplifier
`timescale 1ns/1ps
`include "asm_consts.svh"

// Behaviour
// - Each channel reports its running frequency mode in status bits 6:4.
// - Each channel reports its running power mode in status bits 1:0.
// - Protection status bit 5 shows whether the channel is muted.
// - Bit 4 shows core supply good, bit 3 power-stage supply good.
// - Bit 2 shows second flying capacitor good, bit 1 the first.
// - Bit 0 is set once an over-current event occurred on the channel.
// - Live modulation index shown as 8-bit unsigned, zero to one onto 0..255.
// - Channel 1 registers mirror channel 0 layout four offsets higher.
// - Sticky fault record accumulates every triggered source; software clears it.
// - Both fault registers share one fixed eight-source bit order.
// - Live fault register follows each source: 0 normal, 1 while triggered.
// - Configuration view bits 2:0 show the sampled output-configuration select value.
module asm_status_monitor_regs (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic ce,
  input wire logic [7:0] reg_addr,
  input wire logic reg_rd,
  input wire logic reg_wr,
  input wire asm_pkg::asm_byte_t reg_wdata,
  output asm_pkg::asm_byte_t reg_rdata,
  output logic reg_rd_ack,
  output logic reg_wr_ack,
  output logic reg_hit,
  input wire logic [2:0] ch0_freq_setting,
  input wire logic [1:0] ch0_power_setting,
  input wire logic ch0_muted,
  input wire logic ch0_core_supply_good,
  input wire logic ch0_power_supply_good,
  input wire logic ch0_flycap_two_good,
  input wire logic ch0_flycap_one_good,
  input wire logic ch0_overcurrent_guard,
  input wire logic [7:0] ch0_mod_index,
  input wire logic [2:0] ch1_freq_setting,
  input wire logic [1:0] ch1_power_setting,
  input wire logic ch1_muted,
  input wire logic ch1_core_supply_good,
  input wire logic ch1_power_supply_good,
  input wire logic ch1_flycap_two_good,
  input wire logic ch1_flycap_one_good,
  input wire logic ch1_overcurrent_guard,
  input wire logic [7:0] ch1_mod_index,
  input wire asm_pkg::asm_byte_t fault_source,
  input wire asm_pkg::asm_outcfg_t outcfg_select_pin,
  input wire logic fault_clear,
  output logic fault_live_any,
  output logic fault_sticky_any
);
  import asm_pkg::*;

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  // Shared by the read mux and the hit flag so both agree on the map
  function automatic asm_reg_sel_t reg_decode(input logic [7:0] addr);
    asm_reg_sel_t sel;
    sel = ASM_SEL_NONE;
    unique case (addr)
      `ASM_OFF_CH0_FREQ_POWER: sel = ASM_SEL_CH0_FREQ_POWER;
      `ASM_OFF_CH0_PROTECT: sel = ASM_SEL_CH0_PROTECT;
      `ASM_OFF_CH0_MOD_INDEX: sel = ASM_SEL_CH0_MOD_INDEX;
      `ASM_OFF_CH1_FREQ_POWER: sel = ASM_SEL_CH1_FREQ_POWER;
      `ASM_OFF_CH1_PROTECT: sel = ASM_SEL_CH1_PROTECT;
      `ASM_OFF_CH1_MOD_INDEX: sel = ASM_SEL_CH1_MOD_INDEX;
      `ASM_OFF_FAULT_STICKY: sel = ASM_SEL_FAULT_STICKY;
      `ASM_OFF_OUTCFG_VIEW: sel = ASM_SEL_OUTCFG_VIEW;
      `ASM_OFF_FAULT_LIVE: sel = ASM_SEL_FAULT_LIVE;
      default: sel = ASM_SEL_NONE;
    endcase
    return sel;
  endfunction

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  asm_byte_t ch0_freq_power;
  asm_byte_t ch0_protect;
  asm_byte_t ch0_mod_idx;
  asm_byte_t ch1_freq_power;
  asm_byte_t ch1_protect;
  asm_byte_t ch1_mod_idx;
  asm_byte_t fault_meta_reg;
  asm_byte_t fault_sync_reg;
  asm_byte_t fault_live_reg;
  asm_byte_t fault_live_next;
  asm_byte_t fault_sticky_reg;
  asm_byte_t fault_sticky_next;
  asm_outcfg_t outcfg_meta_reg;
  asm_outcfg_t outcfg_sync_reg;
  asm_outcfg_t outcfg_view_reg;
  asm_reg_sel_t rd_sel;
  asm_byte_t rd_mux;
  asm_byte_t reg_rdata_next;
  logic reg_hit_next;
  logic wr_ignored;

  // ----------------------------------------------------------------
  // Channel monitors
  // ----------------------------------------------------------------
  // Channel status comes from power-stage logic on mclk, so no synchroniser
  asm_chan_mon u_chan0 (
    .mclk(mclk),
    .resetn(resetn),
    .ce(ce),
    .overcurrent_clear(fault_clear),
    .chan_freq_setting(ch0_freq_setting),
    .chan_power_setting(ch0_power_setting),
    .chan_muted(ch0_muted),
    .core_supply_good(ch0_core_supply_good),
    .power_supply_good(ch0_power_supply_good),
    .flycap_two_good(ch0_flycap_two_good),
    .flycap_one_good(ch0_flycap_one_good),
    .overcurrent_guard(ch0_overcurrent_guard),
    .chan_mod_index(ch0_mod_index),
    .freq_power_reg(ch0_freq_power),
    .protect_reg(ch0_protect),
    .mod_index_reg(ch0_mod_idx)
  );

  asm_chan_mon u_chan1 (
    .mclk(mclk),
    .resetn(resetn),
    .ce(ce),
    .overcurrent_clear(fault_clear),
    .chan_freq_setting(ch1_freq_setting),
    .chan_power_setting(ch1_power_setting),
    .chan_muted(ch1_muted),
    .core_supply_good(ch1_core_supply_good),
    .power_supply_good(ch1_power_supply_good),
    .flycap_two_good(ch1_flycap_two_good),
    .flycap_one_good(ch1_flycap_one_good),
    .overcurrent_guard(ch1_overcurrent_guard),
    .chan_mod_index(ch1_mod_index),
    .freq_power_reg(ch1_freq_power),
    .protect_reg(ch1_protect),
    .mod_index_reg(ch1_mod_idx)
  );

  // ----------------------------------------------------------------
  // Fault source synchronisers
  // ----------------------------------------------------------------
  // Sources are independent comparator levels; per-bit skew of one
  // cycle is harmless because each bit is judged on its own
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi = gi + 1) begin : g_fault_sync
      always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
          fault_meta_reg[gi] <= 1'b0;
          fault_sync_reg[gi] <= 1'b0;
        end else if (ce) begin
          fault_meta_reg[gi] <= fault_source[gi];
          fault_sync_reg[gi] <= fault_meta_reg[gi];
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Output-configuration select synchronisers
  // ----------------------------------------------------------------
  // Select straps are static in use; a change mid-sample may show one
  // mixed code for a single cycle
  generate
    for (gi = 0; gi <= `ASM_OUTCFG_MSB; gi = gi + 1) begin : g_outcfg_sync
      always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
          outcfg_meta_reg[gi] <= 1'b0;
          outcfg_sync_reg[gi] <= 1'b0;
        end else if (ce) begin
          outcfg_meta_reg[gi] <= outcfg_select_pin[gi];
          outcfg_sync_reg[gi] <= outcfg_meta_reg[gi];
        end
      end
    end
  endgenerate

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      outcfg_view_reg <= `ASM_RST_OUTCFG;
    end else if (ce) begin
      outcfg_view_reg <= outcfg_sync_reg;
    end
  end

  // ----------------------------------------------------------------
  // Live and sticky fault registers
  // ----------------------------------------------------------------
  // Bit order is carried straight from the source vector into both
  assign fault_live_next = fault_sync_reg;
  // Set wins over clear so an event in the clear cycle is never lost
  assign fault_sticky_next = fault_sync_reg | (fault_sticky_reg & ~{8{fault_clear}});

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      fault_live_reg <= `ASM_RST_BYTE;
      fault_sticky_reg <= `ASM_RST_BYTE;
    end else if (ce) begin
      fault_live_reg <= fault_live_next;
      fault_sticky_reg <= fault_sticky_next;
    end
  end

  assign fault_live_any = |fault_live_reg;
  assign fault_sticky_any = |fault_sticky_reg;

  // ----------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------
  assign rd_sel = reg_decode(reg_addr);
  assign rd_mux =
    (rd_sel == ASM_SEL_CH0_FREQ_POWER) ? ch0_freq_power :
    (rd_sel == ASM_SEL_CH0_PROTECT) ? ch0_protect :
    (rd_sel == ASM_SEL_CH0_MOD_INDEX) ? ch0_mod_idx :
    (rd_sel == ASM_SEL_CH1_FREQ_POWER) ? ch1_freq_power :
    (rd_sel == ASM_SEL_CH1_PROTECT) ? ch1_protect :
    (rd_sel == ASM_SEL_CH1_MOD_INDEX) ? ch1_mod_idx :
    (rd_sel == ASM_SEL_FAULT_STICKY) ? fault_sticky_reg :
    (rd_sel == ASM_SEL_OUTCFG_VIEW) ? {5'h00, outcfg_view_reg} :
    (rd_sel == ASM_SEL_FAULT_LIVE) ? fault_live_reg :
    `ASM_RST_BYTE;

  // Unmapped reads return zero with the hit flag low
  assign reg_rdata_next = reg_rd ? rd_mux : reg_rdata;
  assign reg_hit_next = reg_rd ? (reg_decode(reg_addr) != ASM_SEL_NONE) : reg_hit;
  // Write data is dropped; the access is only acknowledged
  assign wr_ignored = reg_wr & ~reg_rd;

  // ----------------------------------------------------------------
  // Bus answer registers
  // ----------------------------------------------------------------
  // Reading touches no status state, so a read never clears the sticky record
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      reg_rdata <= `ASM_RST_BYTE;
      reg_hit <= 1'b0;
      reg_rd_ack <= 1'b0;
      reg_wr_ack <= 1'b0;
    end else if (ce) begin
      reg_rdata <= reg_rdata_next;
      reg_hit <= reg_hit_next;
      reg_rd_ack <= reg_rd;
      reg_wr_ack <= wr_ignored;
    end
  end

endmodule // asm_status_monitor_regs

// >>> verification/asm_host_model.sv
// Host-side model that issues register reads, writes and fault clears
`timescale 1ns/1ps
module asm_host_model (
  input wire logic mclk,
  input wire logic reg_rd_ack,
  input wire logic reg_wr_ack,
  input wire asm_pkg::asm_byte_t reg_rdata,
  output logic [7:0] reg_addr,
  output logic reg_rd,
  output logic reg_wr,
  output asm_pkg::asm_byte_t reg_wdata,
  output logic fault_clear
);
  import asm_pkg::*;
  initial begin
    reg_addr = 8'hFF;
    reg_rd = 1'b0;
    reg_wr = 1'b0;
    reg_wdata = 8'hFF;
    fault_clear = 1'b0;
  end
  // Released lines show the inverse so stale values never pass
  task automatic rd(input logic [7:0] a, output logic k, output asm_byte_t d);
    @(negedge mclk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge mclk);
    reg_rd = 1'b0;
    reg_addr = ~a;
    k = reg_rd_ack;
    d = reg_rdata;
  endtask
  task automatic wr(input logic [7:0] a, input asm_byte_t w, output logic k);
    @(negedge mclk);
    reg_addr = a;
    reg_wdata = w;
    reg_wr = 1'b1;
    @(negedge mclk);
    reg_wr = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~w;
    k = reg_wr_ack;
  endtask
  task automatic clr();
    @(negedge mclk);
    fault_clear = 1'b1;
    @(negedge mclk);
    fault_clear = 1'b0;
  endtask
endmodule // asm_host_model

// >>> verification/asm_checker.sv
// Port-level assertions for the status monitor bank
`timescale 1ns/1ps
module asm_checker (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic ce,
  input wire logic [7:0] reg_addr,
  input wire logic reg_rd,
  input wire logic reg_wr,
  input wire asm_pkg::asm_byte_t reg_rdata,
  input wire logic reg_wr_ack,
  input wire logic [2:0] ch0_freq_setting,
  input wire logic [1:0] ch1_power_setting,
  input wire logic ch0_muted,
  input wire logic ch0_core_supply_good,
  input wire logic ch0_power_supply_good,
  input wire logic ch0_flycap_two_good,
  input wire logic ch0_flycap_one_good,
  input wire logic ch1_overcurrent_guard,
  input wire logic [7:0] ch1_mod_index,
  input wire asm_pkg::asm_byte_t fault_source,
  input wire asm_pkg::asm_outcfg_t outcfg_select_pin,
  input wire logic fault_clear,
  input wire logic fault_live_any,
  input wire logic fault_sticky_any
);
  import asm_pkg::*;
  logic [2:0] run_reg;
  // Consecutive enabled edges since reset or since ce was low, saturating at 7, so the sync pipeline is known full
  wire [2:0] run_next = !ce ? 3'h0 : (run_reg == 3'h7) ? run_reg : run_reg + 3'h1;
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn)
      run_reg <= 3'h0;
    else
      run_reg <= run_next;
  end
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!resetn);
  sequence s_rd(logic [7:0] a);
    ce && reg_rd && reg_addr == a && run_reg != 3'h0;
  endsequence
  property p_freq;
    s_rd(8'h60) |=> reg_rdata[6:4] == $past(ch0_freq_setting, 2);
  endproperty
  a_freq: assert property (p_freq) else $error("freq field wrong");
  property p_power;
    s_rd(8'h64) |=> reg_rdata[1:0] == $past(ch1_power_setting, 2);
  endproperty
  a_power: assert property (p_power) else $error("power field wrong");
  property p_prot;
    s_rd(8'h61) |=> reg_rdata[5:1] == $past({ch0_muted, ch0_core_supply_good,
      ch0_power_supply_good, ch0_flycap_two_good, ch0_flycap_one_good}, 2);
  endproperty
  a_prot: assert property (p_prot) else $error("protect bits wrong");
  property p_oc;
    ce && ch1_overcurrent_guard ##1 s_rd(8'h65) |=> reg_rdata[0];
  endproperty
  a_oc: assert property (p_oc) else $error("overcurrent bit missing");
  property p_mod;
    s_rd(8'h66) |=> reg_rdata == $past(ch1_mod_index, 2);
  endproperty
  a_mod: assert property (p_mod) else $error("mod index wrong");
  property p_sticky;
    ce && fault_sticky_any && !fault_clear |=> fault_sticky_any;
  endproperty
  a_sticky: assert property (p_sticky) else $error("sticky fault lost");
  property p_live;
    run_reg >= 3'h3 |-> fault_live_any == |$past(fault_source, 3);
  endproperty
  a_live: assert property (p_live) else $error("live fault wrong");
  property p_cfg;
    s_rd(8'h75) ##0 run_reg >= 3'h3 |=> reg_rdata == {5'h00, $past(outcfg_select_pin, 4)};
  endproperty
  a_cfg: assert property (p_cfg) else $error("outcfg view wrong");
  property p_wr;
    ce && reg_wr && !reg_rd |=> reg_wr_ack && $stable(reg_rdata);
  endproperty
  a_wr: assert property (p_wr) else $error("write not ignored");
endmodule // asm_checker
bind asm_status_monitor_regs asm_checker i_asm_checker (.*);

// >>> verification/asm_status_monitor_regs_bench.sv
// Self-checking bench for the status monitor bank
`timescale 1ns/1ps
module asm_status_monitor_regs_bench;
  import asm_pkg::*;
  logic mclk, resetn, ce, reg_rd, reg_wr, reg_rd_ack, reg_wr_ack, reg_hit, fault_clear, k;
  logic fault_live_any, fault_sticky_any;
  logic [7:0] reg_addr, ch0_mod_index, ch1_mod_index;
  asm_byte_t reg_wdata, reg_rdata, fault_source;
  asm_outcfg_t outcfg_select_pin;
  logic [2:0] ch0_freq_setting, ch1_freq_setting;
  logic [1:0] ch0_power_setting, ch1_power_setting;
  logic ch0_muted, ch0_core_supply_good, ch0_power_supply_good, ch0_flycap_two_good;
  logic ch0_flycap_one_good, ch0_overcurrent_guard, ch1_muted, ch1_core_supply_good;
  logic ch1_power_supply_good, ch1_flycap_two_good, ch1_flycap_one_good, ch1_overcurrent_guard;
  logic [7:0] map [9] = '{8'h60, 8'h61, 8'h62, 8'h64, 8'h65, 8'h66, 8'h6D, 8'h75, 8'h7C};
  logic [7:0] exp6 [6] = '{8'h52, 8'h34, 8'hFF, 8'h31, 8'h0A, 8'h80};
  int num_errors = 0;
  int comparisons = 0;
  asm_status_monitor_regs i_asm_status_monitor_regs (.*);
  asm_host_model i_asm_host_model (.*);
  always #5 mclk = ~mclk;
  task automatic wrap_up();
    if (num_errors == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input string n, input asm_byte_t e, input asm_byte_t g);
    comparisons++;
    if (g !== e) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic rc(input logic [7:0] a, input asm_byte_t e, input logic h);
    asm_byte_t d;
    i_asm_host_model.rd(a, k, d);
    chk("read ack", 8'h01, {7'h00, k});
    chk("read data", e, d);
    chk("hit", {7'h00, h}, {7'h00, reg_hit});
  endtask
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    mclk = 1'b0;
    resetn = 1'b0;
    ce = 1'b1;
    fault_source = 8'h00;
    outcfg_select_pin = 3'h0;
    {ch0_freq_setting, ch0_power_setting, ch0_muted, ch0_core_supply_good, ch0_power_supply_good,
      ch0_flycap_two_good, ch0_flycap_one_good, ch0_overcurrent_guard, ch0_mod_index} = 19'h0;
    {ch1_freq_setting, ch1_power_setting, ch1_muted, ch1_core_supply_good, ch1_power_supply_good,
      ch1_flycap_two_good, ch1_flycap_one_good, ch1_overcurrent_guard, ch1_mod_index} = 19'h0;
    repeat (20) @(negedge mclk);
    resetn = 1'b1;
    repeat (2) @(negedge mclk);
    foreach (map[i]) rc(map[i], 8'h00, 1'b1);
    // Protect field layout matches the input order, so one byte sets both
    {ch0_freq_setting, ch0_power_setting, ch0_muted, ch0_core_supply_good, ch0_power_supply_good,
      ch0_flycap_two_good, ch0_flycap_one_good, ch0_overcurrent_guard, ch0_mod_index} =
      {3'h5, 2'h2, 6'h34, 8'hFF};
    {ch1_freq_setting, ch1_power_setting, ch1_muted, ch1_core_supply_good, ch1_power_supply_good,
      ch1_flycap_two_good, ch1_flycap_one_good, ch1_overcurrent_guard, ch1_mod_index} =
      {3'h3, 2'h1, 6'h0A, 8'h80};
    for (int i = 0; i < 6; i++) rc(map[i], exp6[i], 1'b1);
    ch1_overcurrent_guard = 1'b1;
    rc(8'h65, 8'h0B, 1'b1);
    ch1_overcurrent_guard = 1'b0;
    rc(8'h65, 8'h0B, 1'b1);
    i_asm_host_model.clr();
    rc(8'h65, 8'h0A, 1'b1);
    for (int i = 0; i < 8; i++) begin
      fault_source = 8'h01 << i;
      repeat (3) @(negedge mclk);
      rc(8'h7C, 8'h01 << i, 1'b1);
      fault_source = 8'h00;
      repeat (3) @(negedge mclk);
      rc(8'h7C, 8'h00, 1'b1);
      rc(8'h6D, (8'h02 << i) - 8'h01, 1'b1);
    end
    i_asm_host_model.clr();
    rc(8'h6D, 8'h00, 1'b1);
    for (int v = 0; v < 8; v++) begin
      outcfg_select_pin = 3'(v);
      repeat (3) @(negedge mclk);
      rc(8'h75, {5'h00, 3'(v)}, 1'b1);
    end
    i_asm_host_model.wr(8'h6D, 8'hFF, k);
    chk("write ack", 8'h01, {7'h00, k});
    rc(8'h6D, 8'h00, 1'b1);
    rc(8'h63, 8'h00, 1'b0);
    // Enable low must freeze the sync pipeline and fault registers
    fault_source = 8'h04;
    ce = 1'b0;
    repeat (4) @(negedge mclk);
    chk("frozen live any", 8'h00, {7'h00, fault_live_any});
    ce = 1'b1;
    repeat (3) @(negedge mclk);
    chk("live any", 8'h01, {7'h00, fault_live_any});
    chk("sticky any", 8'h01, {7'h00, fault_sticky_any});
    // Mid-run reset empties the sticky record
    resetn = 1'b0;
    fault_source = 8'h00;
    repeat (2) @(negedge mclk);
    resetn = 1'b1;
    repeat (2) @(negedge mclk);
    rc(8'h6D, 8'h00, 1'b1);
    wrap_up();
  end
  initial begin
    repeat (3000) @(posedge mclk);
    num_errors++;
    wrap_up();
  end
endmodule // asm_status_monitor_regs_bench
